/* psm_pkg.sv */
// Constants, types and limits for the pressure switch menu logic
package psm_pkg;
    // Base tick is one centisecond
    localparam int CLK_HZ        = 100_000_000;
    localparam int CS_PER_S      = 100;
    localparam int CYC_PER_CS    = CLK_HZ / CS_PER_S;
    localparam int CS_PER_TENTH  = 10;
    localparam int HOLD_FAST_S   = 5;
    localparam int HOLD_FAST_CS  = HOLD_FAST_S * CS_PER_S;
    localparam int CLEAR_WIN_S   = 1;
    localparam int CLEAR_WIN_CS  = CLEAR_WIN_S * CS_PER_S;
    localparam int MENU_IDLE_S   = 30;
    localparam int MENU_IDLE_CS  = MENU_IDLE_S * CS_PER_S;
    localparam int REP_SLOW_CS   = 50;
    // Filter: step of 1/8 every tau/8, tau in tenths -> period tau*5/4 cs
    localparam int DAMP_SH       = 3;
    localparam int DAMP_NUM      = 5;
    localparam int DAMP_DEN_SH   = 2;

    localparam int N_SLOT        = 16;
    localparam int VAL_W         = 16;

    // Setting slots; slot number equals menu number
    localparam logic [3:0] I_PW     = 4'h0;
    localparam logic [3:0] I_PROT   = 4'h1;
    localparam logic [3:0] I_DP     = 4'h2;
    localparam logic [3:0] I_ZERO   = 4'h3;
    localparam logic [3:0] I_FULL   = 4'h4;
    localparam logic [3:0] I_DAMP   = 4'h5;
    localparam logic [3:0] I_HILO   = 4'h6;
    localparam logic [3:0] I_ON     = 4'h7;
    localparam logic [3:0] I_OFF    = 4'h8;
    localparam logic [3:0] I_MODE   = 4'h9;
    localparam logic [3:0] I_DON    = 4'ha;
    localparam logic [3:0] I_DOFF   = 4'hb;
    localparam logic [3:0] I_PEAK   = 4'hc;
    localparam logic [3:0] I_TROUGH = 4'hd;
    localparam logic [3:0] I_UPD    = 4'he;
    localparam logic [3:0] I_FIRST  = 4'h1;
    localparam logic [3:0] I_LAST   = 4'he;

    localparam logic [15:0] NVM_ERASED = 16'hffff;
    localparam logic [15:0] DEF_PW     = 16'h0005;
    localparam logic [15:0] DEF_FULL   = 16'h270f;
    localparam logic [15:0] DEF_DAMP   = 16'h0003;
    localparam logic [15:0] MAX_DIGITS = 16'h270f;
    localparam logic [15:0] MAX_DP     = 16'h0003;
    localparam logic [15:0] MAX_DAMP   = 16'h012c;
    localparam logic [15:0] MIN_DAMP   = 16'h0003;
    localparam logic [15:0] MAX_DLY    = 16'h03e8;
    localparam logic [15:0] MAX_UPD    = 16'h0064;
    localparam logic [15:0] MAX_BIT    = 16'h0001;

    // Register byte offsets
    localparam logic [4:0] REG_STATUS = 5'h00;
    localparam logic [4:0] REG_DISP   = 5'h04;
    localparam logic [4:0] REG_PEAK   = 5'h08;
    localparam logic [4:0] REG_TROUGH = 5'h0c;
    localparam logic [4:0] REG_CTRL   = 5'h10;
    localparam int ST_CONTACT = 0;
    localparam int ST_PROT    = 1;
    localparam int ST_LOCK    = 2;
    localparam int ST_ITEM    = 4;
    localparam int ST_STATE   = 8;
    localparam int CTRL_LOCK  = 0;

    typedef enum logic [2:0] {
        S_LOAD = 3'b000,
        S_RUN  = 3'b001,
        S_MENU = 3'b010,
        S_EDIT = 3'b011,
        S_VIEW = 3'b100
    } psm_state_t;

    typedef struct packed {
        logic [15:0] value;
        logic [1:0]  dp;
        logic [3:0]  item;
        logic        item_shown;
    } psm_disp_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } psm_nvm_t;

    function automatic logic [15:0] item_max(input logic [3:0] i);
        case (i)
            I_PROT, I_PW, I_ZERO, I_FULL, I_ON, I_OFF: item_max = MAX_DIGITS;
            I_DP:          item_max = MAX_DP;
            I_DAMP:        item_max = MAX_DAMP;
            I_DON, I_DOFF: item_max = MAX_DLY;
            I_UPD:         item_max = MAX_UPD;
            default:       item_max = MAX_BIT;
        endcase
    endfunction : item_max

    function automatic logic [15:0] item_min(input logic [3:0] i);
        item_min = (i == I_DAMP) ? MIN_DAMP : 16'h0000;
    endfunction : item_min

    function automatic logic [15:0] def_val(input logic [3:0] i);
        case (i)
            I_PW:    def_val = DEF_PW;
            I_FULL:  def_val = DEF_FULL;
            I_DAMP:  def_val = DEF_DAMP;
            default: def_val = 16'h0000;
        endcase
    endfunction : def_val
endpackage : psm_pkg

/* psm_top.sv */
// Pressure switch menu, settings and contact logic
// How it works
// [RULE1] LED lit exactly while contact 1 is active.
// [RULE2] Menu wraps from last item to first and back.
// [RULE3] Up: next item or increment; from operation, menu 1.
// [RULE4] Down: previous item or decrement; from operation, last menu.
// [RULE5] Both buttons: open item, or store value and leave.
// [RULE6] One button held over 5 s speeds up counting.
// [RULE7] Edits act only after confirm and leaving.
// [RULE8] Confirmed settings are stored and reloaded at power-up.
// [RULE9] Protection toggles only by password; when active, edits blocked.
// [RULE10] Password is 0005 unless changed.
// [RULE11] One menu sets the decimal point position.
// [RULE12] Zero and full-scale values scale the reading linearly.
// [RULE13] Display filtered first-order, tau 0.3 to 30 s.
// [RULE14] Reaching the on threshold activates contact 1.
// [RULE15] Reaching the off threshold deactivates contact 1.
// [RULE16] Hysteresis or compare mode sets how thresholds act.
// [RULE17] Hysteresis: on at on-point, off at off-point; compare: on in window.
// [RULE18] On delay 0 to 100 s before activating.
// [RULE19] Off delay 0 to 100 s before deactivating.
// [RULE20] Peak and trough kept in volatile flops, shown on request.
// [RULE21] Both buttons within 1 s of showing an extreme clear it.
// [RULE22] Display refresh interval 0.0 to 10 s.
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module psm_top #(
    parameter int CYC_PER_CS = psm_pkg::CYC_PER_CS
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              key_up_i,
    input  wire logic              key_dn_i,
    input  wire logic [15:0]       pressure_i,
    input  wire logic [15:0]       nvm_rdata_i,
    output var  psm_pkg::psm_nvm_t nvm_o,
    output var  psm_pkg::psm_disp_t disp_o,
    output logic                   contact_o,
    output logic                   led_o,
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest
);
    psm_pkg::psm_state_t state_q;
    logic [31:0] div_q;
    logic        cs_tick, up_q, dn_q, lock_q;
    logic        k_up, k_dn, up_ev, dn_ev, confirm;
    logic        held1, rep_fire, step_up, step_dn;
    logic [15:0] hold_q, rep_q, view_q;
    logic [3:0]  item_q;
    logic [15:0] edit_q;
    logic [4:0]  ld_q;
    logic [15:0] live_q [psm_pkg::N_SLOT];
    logic        prot, commit, clr_pk_q, clr_tr_q;
    psm_pkg::psm_nvm_t nvm_q;
    // Centisecond enable for all slow timing
    assign cs_tick = (div_q == 32'(CYC_PER_CS - 1));
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || cs_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 32'd1;
        end
    end
    // Steps fire on a press edge with the other key up; a confirm may follow one step
    assign k_up    = key_up_i & ~lock_q;
    assign k_dn    = key_dn_i & ~lock_q;
    assign up_ev   = k_up & ~up_q & ~k_dn;
    assign dn_ev   = k_dn & ~dn_q & ~k_up;
    assign confirm = k_up & k_dn & ~(up_q & dn_q); // [RULE5]
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else begin
            up_q <= k_up;
            dn_q <= k_dn;
        end
    end
    // Auto repeat: slow, then every tick once held long
    assign held1    = (k_up ^ k_dn) && (state_q == psm_pkg::S_EDIT);
    assign rep_fire = cs_tick && held1 &&
                      ((hold_q >= 16'(psm_pkg::HOLD_FAST_CS)) || // [RULE6]
                       (rep_q >= 16'(psm_pkg::REP_SLOW_CS - 1)));
    assign step_up  = up_ev | (rep_fire & k_up);
    assign step_dn  = dn_ev | (rep_fire & k_dn);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !held1) begin
            hold_q <= '0;
            rep_q  <= '0;
        end else if (cs_tick) begin
            hold_q <= (hold_q == 16'hffff) ? hold_q : hold_q + 16'd1;
            rep_q  <= rep_fire ? 16'h0000 : rep_q + 16'd1;
        end
    end
    // Menu and view timer, restarted by any key
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || up_ev || dn_ev || confirm) begin
            view_q <= '0;
        end else if (cs_tick && view_q != 16'hffff) begin
            view_q <= view_q + 16'd1;
        end
    end
    assign prot   = live_q[psm_pkg::I_PROT][0];
    assign commit = (state_q == psm_pkg::S_EDIT) && confirm;
    // Menu state machine
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q  <= psm_pkg::S_LOAD;
            item_q   <= psm_pkg::I_FIRST;
            edit_q   <= '0;
            ld_q     <= '0;
            clr_pk_q <= 1'b0;
            clr_tr_q <= 1'b0;
        end else begin
            clr_pk_q <= 1'b0;
            clr_tr_q <= 1'b0;
            case (state_q)
                psm_pkg::S_LOAD: begin
                    ld_q <= ld_q + 5'd1;
                    if (ld_q == 5'(psm_pkg::N_SLOT + 1)) begin
                        state_q <= psm_pkg::S_RUN;
                    end
                end
                psm_pkg::S_RUN: begin
                    if (up_ev) begin
                        item_q  <= psm_pkg::I_FIRST; // [RULE3]
                        state_q <= psm_pkg::S_MENU;
                    end else if (dn_ev) begin
                        item_q  <= psm_pkg::I_LAST; // [RULE4]
                        state_q <= psm_pkg::S_MENU;
                    end
                end
                psm_pkg::S_MENU: begin
                    if (confirm) begin
                        if (item_q == psm_pkg::I_PEAK || item_q == psm_pkg::I_TROUGH) begin
                            state_q <= psm_pkg::S_VIEW; // [RULE20]
                        end else if (item_q == psm_pkg::I_PROT) begin
                            state_q <= psm_pkg::S_EDIT; // [RULE9]
                            edit_q  <= '0;
                        end else if (!prot) begin
                            state_q <= psm_pkg::S_EDIT; // [RULE9]
                            edit_q  <= live_q[item_q];
                        end
                    end else if (up_ev) begin
                        item_q <= (item_q == psm_pkg::I_LAST) ? psm_pkg::I_FIRST
                                                             : item_q + 4'd1; // [RULE2] [RULE3]
                    end else if (dn_ev) begin
                        item_q <= (item_q == psm_pkg::I_FIRST) ? psm_pkg::I_LAST
                                                              : item_q - 4'd1; // [RULE2] [RULE4]
                    end else if (view_q >= 16'(psm_pkg::MENU_IDLE_CS)) begin
                        state_q <= psm_pkg::S_RUN;
                    end
                end
                psm_pkg::S_EDIT: begin
                    if (confirm) begin
                        state_q <= psm_pkg::S_MENU; // [RULE5]
                    end else if (step_up) begin
                        edit_q <= (edit_q >= psm_pkg::item_max(item_q)) ?
                                  psm_pkg::item_max(item_q) : edit_q + 16'd1; // [RULE3]
                    end else if (step_dn) begin
                        edit_q <= (edit_q <= psm_pkg::item_min(item_q)) ?
                                  psm_pkg::item_min(item_q) : edit_q - 16'd1; // [RULE4]
                    end
                end
                psm_pkg::S_VIEW: begin
                    if (confirm) begin
                        if (view_q < 16'(psm_pkg::CLEAR_WIN_CS)) begin
                            clr_pk_q <= (item_q == psm_pkg::I_PEAK); // [RULE21]
                            clr_tr_q <= (item_q == psm_pkg::I_TROUGH); // [RULE21]
                        end
                        state_q <= psm_pkg::S_MENU;
                    end else if (up_ev || dn_ev) begin
                        state_q <= psm_pkg::S_MENU;
                    end
                end
                default: state_q <= psm_pkg::S_RUN;
            endcase
        end
    end
    // Applied settings: loaded at start, changed only on commit
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < psm_pkg::N_SLOT; i++) begin
                live_q[i] <= psm_pkg::def_val(4'(i));
            end
            nvm_q <= '0;
        end else begin
            nvm_q.wr <= 1'b0;
            nvm_q.rd <= 1'b0;
            if (state_q == psm_pkg::S_LOAD) begin
                nvm_q.rd   <= (ld_q < 5'(psm_pkg::N_SLOT)); // [RULE8]
                nvm_q.addr <= ld_q[3:0];
                // Data lags the read address by two cycles
                if (ld_q >= 5'd2) begin
                    live_q[4'(ld_q - 5'd2)] <= (nvm_rdata_i == psm_pkg::NVM_ERASED) ?
                        psm_pkg::def_val(4'(ld_q - 5'd2)) : nvm_rdata_i; // [RULE8] [RULE10]
                end
            end else if (commit) begin
                if (item_q == psm_pkg::I_PROT) begin
                    if (edit_q == live_q[psm_pkg::I_PW]) begin
                        live_q[psm_pkg::I_PROT] <= {15'h0000, ~prot}; // [RULE9] [RULE10]
                        nvm_q.wr    <= 1'b1;
                        nvm_q.addr  <= psm_pkg::I_PROT;
                        nvm_q.wdata <= {15'h0000, ~prot};
                    end
                end else begin
                    live_q[item_q] <= edit_q; // [RULE7]
                    nvm_q.wr    <= 1'b1; // [RULE8]
                    nvm_q.addr  <= item_q;
                    nvm_q.wdata <= edit_q;
                end
            end
        end
    end
    assign nvm_o = nvm_q;
    // Linear scaling from zero to full-scale value
    logic signed [17:0] span;
    logic signed [34:0] prod;
    logic signed [18:0] sum_s;
    logic [15:0]        scaled_d, scaled_q;
    assign span = $signed({2'b00, live_q[psm_pkg::I_FULL]}) -
                  $signed({2'b00, live_q[psm_pkg::I_ZERO]}); // [RULE12]
    assign prod  = $signed({1'b0, pressure_i}) * span;
    assign sum_s = $signed({3'b000, live_q[psm_pkg::I_ZERO]}) + prod[34:16];
    always_comb begin
        if (sum_s < 0) begin
            scaled_d = 16'h0000;
        end else if (sum_s > 19'sh0ffff) begin
            scaled_d = 16'hffff;
        end else begin
            scaled_d = sum_s[15:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scaled_q <= '0;
        end else begin
            scaled_q <= scaled_d;
        end
    end
    // Damping: error/8 every tau/8; coarse but divider-free
    logic [15:0]        filt_q, dcnt_q;
    logic [17:0]        dper;
    logic signed [16:0] ferr;
    assign dper = (18'(live_q[psm_pkg::I_DAMP]) * 18'(psm_pkg::DAMP_NUM))
                  >> psm_pkg::DAMP_DEN_SH;
    assign ferr = $signed({1'b0, scaled_q}) - $signed({1'b0, filt_q});
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            filt_q <= '0;
            dcnt_q <= '0;
        end else if (cs_tick) begin
            if (18'(dcnt_q) >= dper) begin
                dcnt_q <= '0;
                filt_q <= filt_q + 16'(ferr >>> psm_pkg::DAMP_SH); // [RULE13]
            end else begin
                dcnt_q <= dcnt_q + 16'd1;
            end
        end
    end
    // Display refresh; zero refreshes every clock
    logic [15:0] ucnt_q, shown_q;
    logic [19:0] uper;
    assign uper = 20'(live_q[psm_pkg::I_UPD]) * 20'(psm_pkg::CS_PER_TENTH);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ucnt_q  <= '0;
            shown_q <= '0;
        end else if (live_q[psm_pkg::I_UPD] == 16'h0000) begin
            shown_q <= filt_q; // [RULE22]
        end else if (cs_tick) begin
            if (20'(ucnt_q) + 20'd1 >= uper) begin
                ucnt_q  <= '0;
                shown_q <= filt_q; // [RULE22]
            end else begin
                ucnt_q <= ucnt_q + 16'd1;
            end
        end
    end
    // Contact 1 conditions and delays
    logic        on_cond, off_cond, in_win, contact_q;
    logic [15:0] lo_th, hi_th, dly_q;
    logic [19:0] don, doff;
    assign lo_th  = (live_q[psm_pkg::I_ON] < live_q[psm_pkg::I_OFF]) ?
                    live_q[psm_pkg::I_ON] : live_q[psm_pkg::I_OFF];
    assign hi_th  = (live_q[psm_pkg::I_ON] < live_q[psm_pkg::I_OFF]) ?
                    live_q[psm_pkg::I_OFF] : live_q[psm_pkg::I_ON];
    assign in_win = (scaled_q >= lo_th) && (scaled_q <= hi_th);
    always_comb begin
        if (live_q[psm_pkg::I_MODE][0]) begin
            on_cond  = in_win; // [RULE16] [RULE17]
            off_cond = ~in_win;
        end else begin
            on_cond  = (scaled_q >= live_q[psm_pkg::I_ON]); // [RULE14] [RULE17]
            off_cond = (scaled_q <= live_q[psm_pkg::I_OFF]); // [RULE15] [RULE17]
        end
    end
    assign don  = 20'(live_q[psm_pkg::I_DON]) * 20'(psm_pkg::CS_PER_TENTH);
    assign doff = 20'(live_q[psm_pkg::I_DOFF]) * 20'(psm_pkg::CS_PER_TENTH);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || state_q == psm_pkg::S_LOAD) begin
            contact_q <= 1'b0;
            dly_q     <= '0;
        end else if (contact_q ? !off_cond : !on_cond) begin
            dly_q <= '0;
        end else if (20'(dly_q) >= (contact_q ? doff : don)) begin
            contact_q <= ~contact_q; // [RULE18] [RULE19]
            dly_q     <= '0;
        end else if (cs_tick) begin
            dly_q <= dly_q + 16'd1;
        end
    end
    assign contact_o = contact_q;
    assign led_o     = contact_q; // [RULE1]
    // Extremes live only in flops, lost with the supply
    logic [15:0] pk_q, tr_q;
    logic        pk_v, tr_v;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || state_q == psm_pkg::S_LOAD) begin
            pk_q <= '0;
            tr_q <= '0;
            pk_v <= 1'b0;
            tr_v <= 1'b0;
        end else begin
            pk_v <= 1'b1;
            tr_v <= 1'b1;
            if (clr_pk_q || !pk_v || scaled_q > pk_q) begin
                pk_q <= scaled_q; // [RULE20] [RULE21]
            end
            if (clr_tr_q || !tr_v || scaled_q < tr_q) begin
                tr_q <= scaled_q; // [RULE20] [RULE21]
            end
        end
    end
    // Display register
    psm_pkg::psm_disp_t disp_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            disp_q <= '0;
        end else begin
            disp_q.dp         <= live_q[psm_pkg::I_DP][1:0]; // [RULE11]
            disp_q.item       <= item_q;
            disp_q.item_shown <= (state_q == psm_pkg::S_MENU);
            case (state_q)
                psm_pkg::S_MENU: disp_q.value <= {12'h000, item_q};
                psm_pkg::S_EDIT: disp_q.value <= edit_q;
                psm_pkg::S_VIEW: disp_q.value <= (item_q == psm_pkg::I_PEAK) ? pk_q : tr_q;
                default:         disp_q.value <= shown_q;
            endcase
        end
    end
    assign disp_o = disp_q;
    // Avalon-MM slave, one wait state
    logic        ack_q;
    logic [31:0] rdata_q, rmux;
    logic        req;
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata    = rdata_q;
    always_comb begin
        rmux = 32'h0000_0000;
        case (avs_address)
            psm_pkg::REG_STATUS: begin
                rmux[psm_pkg::ST_CONTACT]        = contact_q;
                rmux[psm_pkg::ST_PROT]           = prot;
                rmux[psm_pkg::ST_LOCK]           = lock_q;
                rmux[psm_pkg::ST_ITEM +: 4]      = item_q;
                rmux[psm_pkg::ST_STATE +: 3]     = state_q;
            end
            psm_pkg::REG_DISP:   rmux[15:0] = shown_q;
            psm_pkg::REG_PEAK:   rmux[15:0] = pk_q;
            psm_pkg::REG_TROUGH: rmux[15:0] = tr_q;
            psm_pkg::REG_CTRL:   rmux[psm_pkg::CTRL_LOCK] = lock_q;
            default:             rmux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
            lock_q  <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
            if (avs_read && !ack_q) begin
                rdata_q <= rmux;
            end
            if (avs_write && ack_q && avs_address == psm_pkg::REG_CTRL &&
                avs_byteenable[0]) begin
                lock_q <= avs_writedata[psm_pkg::CTRL_LOCK];
            end
        end
    end
endmodule : psm_top
`default_nettype wire

/* psm_monitor.sv */
// Checker for the pressure switch menu ports
`timescale 1ns/10ps
`default_nettype none
module psm_monitor (
    input wire logic               clk_i,
    input wire logic               rst_n_i,
    input wire psm_pkg::psm_nvm_t  nvm_o,
    input wire psm_pkg::psm_disp_t disp_o,
    input wire logic               contact_o,
    input wire logic               led_o,
    input wire logic [4:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest
);
    function automatic logic [3:0] nxt(input logic [3:0] x);
        nxt = (x == 4'he) ? 4'h1 : x + 4'h1;
    endfunction : nxt
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    led_tracks_a: assert property (led_o == contact_o)
        else $error("LED mismatch");
    menu_wrap_a: assert property (disp_o.item_shown && $past(disp_o.item_shown)
        && $changed(disp_o.item) |-> disp_o.item == nxt($past(disp_o.item))
        || $past(disp_o.item) == nxt(disp_o.item)) else $error("Bad menu step");
    load_start_a: assert property ($rose(rst_n_i) |-> ##[0:3] (nvm_o.rd && nvm_o.addr == 4'h0))
        else $error("No reload start");
    load_open_a: assert property ($rose(rst_n_i) |-> !contact_o [*8])
        else $error("Contact in load");
    read_seq_a: assert property (nvm_o.rd && nvm_o.addr != 4'hf |=> nvm_o.rd
        && nvm_o.addr == $past(nvm_o.addr) + 4'h1) else $error("Reload gap");
    read_end_a: assert property ($fell(nvm_o.rd) |-> $past(nvm_o.addr) == 4'hf)
        else $error("Reload short");
    write_pulse_a: assert property (nvm_o.wr |=> !nvm_o.wr && !nvm_o.rd)
        else $error("Write not a pulse");
    bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Extra wait state");
    unmapped_a: assert property (avs_read && !avs_waitrequest && avs_address > 5'h10
        |-> avs_readdata == 32'h0) else $error("Unmapped read");
    cover property ($rose(contact_o));
    cover property ($fell(contact_o));
    cover property (nvm_o.wr);
endmodule : psm_monitor
bind psm_top psm_monitor psm_monitor_i (.clk_i, .rst_n_i, .nvm_o, .disp_o, .contact_o, .led_o,
    .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest);
`default_nettype wire

/* psm_store_model.sv */
// Non-volatile settings store; contents survive resets
`timescale 1ns/10ps
`default_nettype none
module psm_store_model (
    input  wire logic              clk_i,
    input  wire psm_pkg::psm_nvm_t nvm_i,
    output logic [15:0]            rdata_o
);
    logic [15:0] mem [16];
    initial begin
        for (int k = 0; k < 16; k++) begin
            mem[k] = psm_pkg::NVM_ERASED;
        end
    end
    always @(posedge clk_i) begin
        if (nvm_i.wr) begin
            mem[nvm_i.addr] <= nvm_i.wdata;
        end
        if (nvm_i.rd) begin
            rdata_o <= mem[nvm_i.addr];
        end else begin
            rdata_o <= ~rdata_o;  // Garbage outside a read
        end
    end
endmodule : psm_store_model
`default_nettype wire

/* psm_top_bench.sv */
// Bench for the pressure switch menu logic
`timescale 1ns/10ps
`default_nettype none
module psm_top_bench;
    logic               clk_i, rst_n_i, key_up_i, key_dn_i, avs_read, avs_write;
    logic               avs_waitrequest, contact_o, led_o;
    logic [15:0]        pressure_i, nvm_rdata_i;
    logic [4:0]         avs_address;
    logic [31:0]        avs_writedata, avs_readdata, rd_q;
    psm_pkg::psm_nvm_t  nvm_o;
    psm_pkg::psm_disp_t disp_o;
    int                 failures, num_checks;
    psm_top #(.CYC_PER_CS(10)) psm_top_i (.clk_i, .rst_n_i, .key_up_i, .key_dn_i, .pressure_i,
        .nvm_rdata_i, .nvm_o, .disp_o, .contact_o, .led_o, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest);
    psm_store_model psm_store_model_i (.clk_i(clk_i), .nvm_i(nvm_o), .rdata_o(nvm_rdata_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        @(posedge clk_i);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                failures++;
                summarize();
            end
            @(posedge clk_i);
        end
        rd_q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
        bus(1'b0, psm_pkg::REG_STATUS, 32'h0);
        chk(rd_q & mask, exp);
    endtask : stat
    task automatic key(input logic u, input logic dn);
        key_up_i <= u;
        key_dn_i <= dn;
        repeat (4) @(posedge clk_i);
        key_up_i <= 1'b0;
        key_dn_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : key
    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (30) @(posedge clk_i);
    endtask : do_reset
    task automatic t_bus();
        bus(1'b0, 5'h14, 32'h0);
        chk(rd_q, 32'h0);
        bus(1'b1, psm_pkg::REG_STATUS, 32'hffff_ffff);
        stat(32'h700, 32'h100);
        bus(1'b1, psm_pkg::REG_CTRL, 32'h1);
        key(1'b1, 1'b0);
        stat(32'h704, 32'h104);
        bus(1'b1, psm_pkg::REG_CTRL, 32'h0);
        $display("Test bus done");
    endtask : t_bus
    task automatic t_menu();
        key(1'b1, 1'b0);
        stat(32'h7f0, 32'h210);
        key(1'b0, 1'b1);
        stat(32'h7f0, 32'h2e0);
        key(1'b1, 1'b0);
        stat(32'h7f0, 32'h210);
        $display("Test menu done");
    endtask : t_menu
    task automatic t_mode();
        chk(32'(contact_o), 32'h1);
        repeat (6) key(1'b0, 1'b1);
        key(1'b1, 1'b1);
        stat(32'h7f0, 32'h390);
        key(1'b1, 1'b0);
        chk(32'(contact_o), 32'h1);
        key(1'b1, 1'b1);
        stat(32'h7f0, 32'h290);
        chk(32'(contact_o), 32'h0);
        chk(32'(psm_store_model_i.mem[9]), 32'h1);
        do_reset();
        chk(32'(contact_o), 32'h0);
        $display("Test mode done");
    endtask : t_mode
    task automatic t_pass();
        key(1'b1, 1'b0);
        key(1'b1, 1'b1);
        repeat (5) key(1'b1, 1'b0);
        key(1'b1, 1'b1);
        stat(32'h7f2, 32'h212);
        key(1'b0, 1'b1);
        key(1'b1, 1'b1);
        stat(32'h7f0, 32'h2e0);
        $display("Test password done");
    endtask : t_pass
    initial begin
        failures      = 0;
        num_checks    = 0;
        rst_n_i       = 1'b0;
        key_up_i      = 1'b0;
        key_dn_i      = 1'b0;
        pressure_i    = 16'hffff;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_address   = 5'h00;
        avs_writedata = 32'h0;
        do_reset();
        t_bus();
        t_menu();
        t_mode();
        t_pass();
        summarize();
    end
endmodule : psm_top_bench
`default_nettype wire
